// [design/flash_operand_pkg.sv]
// constants and types shared by the flash operand register block
`default_nettype none
package flash_operand_pkg;

	// ==========================================================
	// register indices on the register port
	localparam logic [2:0] IDX_TARGET_ADDR = 3'h0;
	localparam logic [2:0] IDX_DATA_LOW    = 3'h1;
	localparam logic [2:0] IDX_DATA_HIGH   = 3'h2;
	localparam logic [2:0] IDX_SRC_ADDR    = 3'h3;

	// ==========================================================
	// reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ==========================================================
	// operation codes
	localparam logic [3:0] OP_NOP         = 4'h0;
	localparam logic [3:0] OP_WORD_PROG   = 4'h1;
	localparam logic [3:0] OP_DWORD_PROG  = 4'h2;
	localparam logic [3:0] OP_ROW_PROG    = 4'h3;
	localparam logic [3:0] OP_PAGE_ERASE  = 4'h4;
	localparam logic [3:0] OP_ARRAY_ERASE = 4'h5;
	localparam logic [3:0] OP_NOP_ALT     = 4'h6;

	// ==========================================================
	// array geometry defaults
	localparam int ROW_BYTES_DEF  = 512;
	localparam int PAGE_BYTES_DEF = 4096;

	typedef struct packed {
		logic [3:0]  code;
		logic [31:0] target;
		logic [31:0] data_low;
		logic [31:0] data_high;
		logic [31:0] source;
	} operand_set_t;

endpackage
`default_nettype wire

// [design/flash_operand_registers.sv]
// flash operand registers with operand capture at operation start
`default_nettype none

// Contract
// RULE1: 32-bit read/write target address register, zero after reset.
// RULE2: whole-array erase ignores the target address completely.
// RULE3: page erase uses target address to pick the page.
// RULE4: row program uses target address to pick the row.
// RULE5: word program uses target address to pick one word.
// RULE6: software writes physical addresses; hardware passes them untranslated.
// RULE7: word/row-only variant has exactly one 32-bit data register.
// RULE8: double-word variant has two data registers; first is low word.
// RULE9: second data register supplies the upper 32 bits.
// RULE10: data registers clear only on power-on reset.
// RULE11: 32-bit read/write source buffer address register for row program.
// RULE12: software keeps the source address word-aligned before row program.
// RULE13: row program reads row data from the source physical address.
// RULE14: op codes 1..5 as listed; 0 and 6 no-op; higher reserved.
// RULE15: row program drops sub-row address bits, starts at row start.
// RULE16: operands are captured at start; later writes do not disturb.
module flash_operand_registers
	import flash_operand_pkg::*;
#(
	parameter bit DOUBLE_WORD = 1'b1,
	parameter int ROW_BYTES   = ROW_BYTES_DEF,
	parameter int PAGE_BYTES  = PAGE_BYTES_DEF
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	input  wire logic [2:0]  REG_INDEX_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	output var  logic [31:0] REG_RDATA_OUT,
	output var  logic        REG_ERR_OUT,
	input  wire logic        OP_START_IN,
	input  wire logic [3:0]  OP_CODE_IN,
	output var  logic        OP_VALID_OUT,
	output var  logic        OP_REJECT_OUT,
	output var  logic [3:0]  OP_CODE_OUT,
	output var  logic [31:0] FLASH_ADDR_OUT,
	output var  logic [63:0] PROG_DATA_OUT,
	output var  logic [31:0] SRC_ADDR_OUT
);

	localparam int ROW_BITS  = $clog2(ROW_BYTES);
	localparam int PAGE_BITS = $clog2(PAGE_BYTES);

	// ==========================================================
	// helpers
	function automatic logic [31:0] align_down(input logic [31:0] a,
		input int bits);
		logic [31:0] mask;
		mask = ~((32'h0000_0001 << bits) - 32'h0000_0001);
		return a & mask;
	endfunction

	function automatic logic op_supported(input logic [3:0] c);
		logic ok;
		ok = 1'b0;
		case (c)
			OP_WORD_PROG, OP_ROW_PROG, OP_PAGE_ERASE,
			OP_ARRAY_ERASE: ok = 1'b1;
			OP_DWORD_PROG:  ok = DOUBLE_WORD; // [RULE14]
			default:        ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic index_mapped(input logic [2:0] i);
		logic ok;
		ok = 1'b0;
		case (i)
			IDX_TARGET_ADDR, IDX_DATA_LOW, IDX_SRC_ADDR: ok = 1'b1;
			IDX_DATA_HIGH: ok = DOUBLE_WORD; // [RULE7] [RULE8]
			default:       ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ==========================================================
	// software-visible registers
	logic [31:0] target_addr;
	logic [31:0] next_target_addr;
	logic [31:0] src_addr;
	logic [31:0] next_src_addr;
	logic [31:0] data_low;
	logic [31:0] next_data_low;
	logic [31:0] data_high;
	logic [31:0] next_data_high;
	logic [31:0] next_rdata;
	logic        next_err;
	logic        wr_ok;

	always_comb begin
		wr_ok            = REG_WR_IN && index_mapped(REG_INDEX_IN);
		next_target_addr = target_addr;
		next_src_addr    = src_addr;
		next_data_low    = data_low;
		next_data_high   = data_high;
		if (wr_ok) begin
			case (REG_INDEX_IN)
				IDX_TARGET_ADDR: next_target_addr = REG_WDATA_IN; // [RULE1]
				IDX_SRC_ADDR:    next_src_addr = REG_WDATA_IN; // [RULE11]
				IDX_DATA_LOW:    next_data_low = REG_WDATA_IN; // [RULE8]
				IDX_DATA_HIGH:   next_data_high = REG_WDATA_IN; // [RULE9]
				default: ;
			endcase
		end
		next_rdata = RESET_WORD;
		next_err   = (REG_WR_IN || REG_RD_IN) &&
			!index_mapped(REG_INDEX_IN);
		if (REG_RD_IN) begin
			case (REG_INDEX_IN)
				IDX_TARGET_ADDR: next_rdata = target_addr;
				IDX_SRC_ADDR:    next_rdata = src_addr;
				IDX_DATA_LOW:    next_rdata = data_low;
				IDX_DATA_HIGH:   next_rdata = DOUBLE_WORD ?
					data_high : RESET_WORD;
				default:         next_rdata = RESET_WORD;
			endcase
		end
	end

	// address registers clear on any reset
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			target_addr <= RESET_WORD; // [RULE1]
			src_addr    <= RESET_WORD;
		end else if (SYS_RST_IN) begin
			target_addr <= RESET_WORD;
			src_addr    <= RESET_WORD;
		end else begin
			target_addr <= next_target_addr;
			src_addr    <= next_src_addr;
		end
	end

	// data registers survive the system reset, only power-on clears them
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			data_low  <= RESET_WORD; // [RULE10]
			data_high <= RESET_WORD;
		end else begin
			data_low  <= next_data_low;
			data_high <= next_data_high;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT <= RESET_WORD;
			REG_ERR_OUT   <= 1'b0;
		end else begin
			REG_RDATA_OUT <= next_rdata;
			REG_ERR_OUT   <= next_err;
		end
	end

	// ==========================================================
	// operand capture
	operand_set_t held;
	operand_set_t next_held;
	logic         next_valid;
	logic         next_reject;

	always_comb begin
		next_held   = held;
		next_valid  = 1'b0;
		next_reject = 1'b0;
		if (OP_START_IN && !SYS_RST_IN) begin
			if (op_supported(OP_CODE_IN)) begin
				// snapshot so later register writes cannot leak in
				next_valid          = 1'b1; // [RULE16]
				next_held.code      = OP_CODE_IN;
				next_held.data_low  = data_low;
				next_held.data_high = DOUBLE_WORD ? data_high : RESET_WORD;
				next_held.source    = RESET_WORD;
				// address goes out untranslated, only aligned or zeroed per operation
				case (OP_CODE_IN) // [RULE6]
					OP_ARRAY_ERASE: next_held.target = RESET_WORD; // [RULE2]
					OP_PAGE_ERASE:  next_held.target =
						align_down(target_addr, PAGE_BITS); // [RULE3]
					OP_ROW_PROG: begin
						next_held.target =
							align_down(target_addr, ROW_BITS); // [RULE4] [RULE15]
						next_held.source = src_addr; // [RULE13]
					end
					OP_WORD_PROG:   next_held.target = target_addr; // [RULE5]
					OP_DWORD_PROG:  next_held.target = target_addr; // [RULE9]
					default:        next_held.target = RESET_WORD;
				endcase
			end else if (OP_CODE_IN != OP_NOP && OP_CODE_IN != OP_NOP_ALT) begin
				next_reject = 1'b1; // [RULE14]
			end
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			held          <= '0;
			OP_VALID_OUT  <= 1'b0;
			OP_REJECT_OUT <= 1'b0;
		end else begin
			held          <= next_held;
			OP_VALID_OUT  <= next_valid;
			OP_REJECT_OUT <= next_reject;
		end
	end

	// outputs are the held snapshot, straight from flip-flops
	always_comb begin
		OP_CODE_OUT    = held.code;
		FLASH_ADDR_OUT = held.target;
		PROG_DATA_OUT  = {held.data_high, held.data_low}; // [RULE8] [RULE9]
		SRC_ADDR_OUT   = held.source;
	end

endmodule
`default_nettype wire

// [tb/flash_operand_asserts.sv]
// assertions on the flash operand register ports
`default_nettype none
module flash_operand_asserts
	import flash_operand_pkg::*;
#(parameter int ROW_BYTES = ROW_BYTES_DEF) (
	input wire logic        CLK_IN, RST_IN, SYS_RST_IN,
	input wire logic        REG_WR_IN, REG_RD_IN, OP_START_IN,
	input wire logic [2:0]  REG_INDEX_IN,
	input wire logic [31:0] REG_WDATA_IN, REG_RDATA_OUT,
	input wire logic        REG_ERR_OUT, OP_VALID_OUT, OP_REJECT_OUT,
	input wire logic [3:0]  OP_CODE_IN, OP_CODE_OUT,
	input wire logic [31:0] FLASH_ADDR_OUT, SRC_ADDR_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	logic go;
	assign go = OP_START_IN && !SYS_RST_IN;
	// ==========================================================
	// register port
	sequence s_wr_tgt;
		REG_WR_IN && REG_INDEX_IN == IDX_TARGET_ADDR && !SYS_RST_IN
		##1 REG_RD_IN && REG_INDEX_IN == IDX_TARGET_ADDR && !SYS_RST_IN;
	endsequence
	a_addr_rdback: assert property (s_wr_tgt |=>
		REG_RDATA_OUT == $past(REG_WDATA_IN, 2)) else $error("readback");
	a_rd_idle: assert property (!REG_RD_IN |=>
		REG_RDATA_OUT == 32'h0) else $error("rdata not idle");
	a_err_read: assert property (REG_RD_IN && REG_INDEX_IN > 3'h3
		|=> REG_ERR_OUT && REG_RDATA_OUT == 32'h0) else $error("unmapped");
	// ==========================================================
	// operation start and snapshot
	a_op_valid: assert property (go && OP_CODE_IN inside
		{[OP_WORD_PROG:OP_ARRAY_ERASE]} |=> OP_VALID_OUT &&
		OP_CODE_OUT == $past(OP_CODE_IN)) else $error("no accept");
	a_op_nop: assert property (OP_START_IN && (OP_CODE_IN == OP_NOP
		|| OP_CODE_IN == OP_NOP_ALT) |=> !OP_VALID_OUT && !OP_REJECT_OUT
		&& $stable(FLASH_ADDR_OUT)) else $error("nop acted");
	a_op_reject: assert property (go && OP_CODE_IN > OP_NOP_ALT
		|=> OP_REJECT_OUT && !OP_VALID_OUT) else $error("no reject");
	a_erase_ign: assert property (OP_VALID_OUT &&
		OP_CODE_OUT == OP_ARRAY_ERASE |-> FLASH_ADDR_OUT == 32'h0)
		else $error("erase addr");
	a_row_align: assert property (OP_VALID_OUT &&
		OP_CODE_OUT == OP_ROW_PROG |-> FLASH_ADDR_OUT % ROW_BYTES == 0)
		else $error("row addr");
	a_src_other: assert property (OP_VALID_OUT &&
		OP_CODE_OUT != OP_ROW_PROG |-> SRC_ADDR_OUT == 32'h0)
		else $error("src addr");
	a_snap_hold: assert property (!OP_VALID_OUT |->
		$stable(FLASH_ADDR_OUT) && $stable(SRC_ADDR_OUT))
		else $error("snapshot moved");
endmodule
bind flash_operand_registers flash_operand_asserts
	#(.ROW_BYTES(ROW_BYTES)) u_chk (.*);
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the flash operand registers
`default_nettype none
module tb_top import flash_operand_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_IN = 0, RST_IN = 1, SYS_RST_IN = 0, REG_WR_IN = 0;
	logic        REG_RD_IN = 0, OP_START_IN = 0;
	logic [2:0]  REG_INDEX_IN = 0;
	logic [31:0] REG_WDATA_IN = 0, REG_RDATA_OUT, FLASH_ADDR_OUT;
	logic [31:0] SRC_ADDR_OUT;
	logic [3:0]  OP_CODE_IN = 0, OP_CODE_OUT;
	logic        REG_ERR_OUT, OP_VALID_OUT, OP_REJECT_OUT;
	logic [63:0] PROG_DATA_OUT;
	logic [31:0] ea [1:5] = '{32'h1234, 32'h1234, 32'h1200, 32'h1000, 0};
	int          err_total = 0, total_checks = 0, cyc = 0;
	flash_operand_registers u_dut (.*);
	always #4 CLK_IN = ~CLK_IN;
	task cmp(string n, logic [63:0] e, logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard: the whole run needs about 80 cycles
	always @(posedge CLK_IN) begin
		if (++cyc == 1000) begin
			err_total++;
			stop_test;
		end
	end
	task wr(logic [2:0] i, logic [31:0] d);
		@(negedge CLK_IN);
		REG_WR_IN = 1;
		REG_INDEX_IN = i;
		REG_WDATA_IN = d;
		@(negedge CLK_IN);
		REG_WR_IN = 0;
	endtask
	task rd(logic [2:0] i, logic [31:0] e, logic ee);
		@(negedge CLK_IN);
		REG_RD_IN = 1;
		REG_INDEX_IN = i;
		@(negedge CLK_IN);
		REG_RD_IN = 0;
		cmp("rdata", e, REG_RDATA_OUT);
		cmp("err", ee, REG_ERR_OUT);
	endtask
	// vr is {valid, reject}; ec, a, s are the expected snapshot
	task op(logic [3:0] c, logic [1:0] vr, logic [3:0] ec, logic [31:0] a, s);
		@(negedge CLK_IN);
		OP_START_IN = 1;
		OP_CODE_IN = c;
		@(negedge CLK_IN);
		OP_START_IN = 0;
		cmp("vld_rej", vr, {OP_VALID_OUT, OP_REJECT_OUT});
		cmp("code", ec, OP_CODE_OUT);
		cmp("addr", a, FLASH_ADDR_OUT);
		cmp("src", s, SRC_ADDR_OUT);
	endtask
	initial begin
		repeat (2) @(negedge CLK_IN);
		RST_IN = 0;
		for (int i = 0; i < 4; i++)
			rd(i, 0, 0);
		wr(IDX_TARGET_ADDR, 32'h0000_1234);
		wr(IDX_DATA_LOW, 32'hA5A5_0001);
		wr(IDX_DATA_HIGH, 32'h5A5A_0002);
		wr(IDX_SRC_ADDR, 32'h0000_0080);
		rd(IDX_DATA_HIGH, 32'h5A5A_0002, 0);
		rd(IDX_SRC_ADDR, 32'h0000_0080, 0);
		rd(3'h5, 0, 1);
		for (int c = 1; c < 6; c++) begin
			op(c, 2, c, ea[c], c == 3 ? 32'h80 : 0);
			cmp("pdata", 64'h5A5A_0002_A5A5_0001, PROG_DATA_OUT);
		end
		op(OP_ROW_PROG, 2, 3, 32'h1200, 32'h80);
		for (int c = 0; c < 16; c++)
			if (c == 0 || c > 5)
				op(c, c > 6, 3, 32'h1200, 32'h80);
		fork
			wr(IDX_TARGET_ADDR, 32'h0000_2000);
			op(OP_WORD_PROG, 2, 1, 32'h1234, 0);
		join
		rd(IDX_TARGET_ADDR, 32'h0000_2000, 0);
		// write then read in the very next cycle
		@(negedge CLK_IN);
		REG_WR_IN = 1;
		REG_INDEX_IN = IDX_TARGET_ADDR;
		REG_WDATA_IN = 32'h0000_3000;
		@(negedge CLK_IN);
		REG_WR_IN = 0;
		REG_RD_IN = 1;
		@(negedge CLK_IN);
		REG_RD_IN = 0;
		cmp("rdata_b2b", 32'h0000_3000, REG_RDATA_OUT);
		wr(3'h6, 32'hFFFF_FFFF);
		cmp("wr_err", 1, REG_ERR_OUT);
		rd(IDX_TARGET_ADDR, 32'h0000_3000, 0);
		// system reset blocks a start but lets a data write land
		@(negedge CLK_IN);
		SYS_RST_IN = 1;
		OP_START_IN = 1;
		OP_CODE_IN = OP_WORD_PROG;
		REG_WR_IN = 1;
		REG_INDEX_IN = IDX_DATA_LOW;
		REG_WDATA_IN = 32'h1111_2222;
		@(negedge CLK_IN);
		SYS_RST_IN = 0;
		OP_START_IN = 0;
		REG_WR_IN = 0;
		cmp("vld_rej_rst", 0, {OP_VALID_OUT, OP_REJECT_OUT});
		rd(IDX_TARGET_ADDR, 0, 0);
		rd(IDX_DATA_LOW, 32'h1111_2222, 0);
		RST_IN = 1;
		@(negedge CLK_IN);
		RST_IN = 0;
		rd(IDX_DATA_LOW, 0, 0);
		stop_test;
	end
endmodule
`default_nettype wire
